// ==== hw/pic_pkg.sv ====
// Constants and types shared by the port ingress control register block
package pic_pkg;

   // ***************************************************************
   // Register indices (port-relative) and the bus address width
   // ***************************************************************
   localparam logic [11:0] IDX_BE_MSB   = 12'h610;
   localparam logic [11:0] IDX_BE_LSB   = 12'h611;
   localparam logic [11:0] IDX_RULE_ACC = 12'h612;
   localparam logic [11:0] IDX_MIRROR   = 12'h800;
   localparam logic [11:0] IDX_PRIO     = 12'h801;
   localparam logic [11:0] IDX_DFLT     = 12'h802;
   localparam int          ADDR_W       = 16;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int RA_WR_DONE = 6;
   localparam int RA_RD_DONE = 5;
   localparam int RA_DIR     = 4;
   localparam int MIR_RX     = 6;
   localparam int MIR_TX     = 5;
   localparam int MIR_SNIFF  = 1;
   localparam int PR_HIGHEST = 7;
   localparam int PR_OR      = 6;
   localparam int NSRC       = 5;

   // ***************************************************************
   // Reset values and writable-bit masks
   // ***************************************************************
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [2:0] RST_DFLT      = 3'h0;
   localparam logic [7:0] MASK_RULE_ACC = 8'h1f;
   localparam logic [7:0] MASK_MIRROR   = 8'h62;
   localparam logic [7:0] MASK_PRIO     = 8'hdf;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   // Indirect access engine states
   typedef enum logic [1:0]
   {
      ENG_IDLE = 2'h1,
      ENG_BUSY = 2'h2
   } pic_eng_type;

endpackage

// ==== hw/pic_prio_if.sv ====
// Interface between register block and priority resolver
interface pic_prio_if;
   import pic_pkg::*;
   logic                      pkt_valid;
   logic [NSRC-1:0]           src_en;
   logic [NSRC-1:0]           src_valid;
   logic [NSRC-1:0][2:0]      src_prio;
   logic                      highest;
   logic                      or_mode;
   logic [2:0]                dflt;
   logic                      res_valid;
   logic [2:0]                res_prio;

   modport ctrl (output pkt_valid, src_en, src_valid, src_prio, highest,
                 or_mode, dflt, input res_valid, res_prio);
   modport comb (input pkt_valid, src_en, src_valid, src_prio, highest,
                 or_mode, dflt, output res_valid, res_prio);
endinterface

// ==== hw/pic_prio_resolve.sv ====
// Ingress priority resolver: merges enabled classification results
module pic_prio_resolve
   import pic_pkg::*;
(
   // Clock and reset
   input  wire logic  ref_clk,
   input  wire logic  rst_b,
   // Classification sources and result
   pic_prio_if.comb   p
);

   logic       res_valid_r;
   logic       res_valid_nxt;
   logic [2:0] res_prio_r;
   logic [2:0] res_prio_nxt;

   // Source 0 (rule match) has the strongest precedence in plain mode
   always_comb
   begin
      logic       any;
      logic [2:0] hi;
      logic [2:0] orv;
      logic [2:0] first;
      any   = 1'b0;
      hi    = 3'h0;
      orv   = 3'h0;
      first = 3'h0;
      for (int i = NSRC - 1; i >= 0; i--)
      begin
         if (p.src_en[i] && p.src_valid[i])
         begin
            any   = 1'b1;
            orv   = orv | p.src_prio[i];
            first = p.src_prio[i];
            if (p.src_prio[i] > hi)
               hi = p.src_prio[i];
         end
      end
      res_valid_nxt = p.pkt_valid;
      if (!p.pkt_valid)
         res_prio_nxt = res_prio_r;
      else if (!any)
         res_prio_nxt = p.dflt;
      else if (p.highest)
         res_prio_nxt = hi;
      else if (p.or_mode)
         res_prio_nxt = orv;
      else
         res_prio_nxt = first;
   end

   // Result registers
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         res_valid_r <= 1'b0;
         res_prio_r  <= 3'h0;
      end
      else
      begin
         res_valid_r <= res_valid_nxt;
         res_prio_r  <= res_prio_nxt;
      end
   end

   assign p.res_valid = res_valid_r;
   assign p.res_prio  = res_prio_r;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   highest_pick_a: assert property (p.pkt_valid && p.highest &&
      p.src_en[0] && p.src_valid[0] && p.src_prio[0] == 3'h7
      |=> res_prio_r == 3'h7 && res_valid_r)
      else $error("highest mode missed priority 7");
   or_merge_a: assert property (p.pkt_valid && !p.highest &&
      p.or_mode && p.src_en[1] && p.src_valid[1]
      |=> (res_prio_r & $past(p.src_prio[1])) == $past(p.src_prio[1]))
      else $error("OR mode dropped a source bit");
   default_prio_a: assert property (p.pkt_valid &&
      (p.src_en & p.src_valid) == '0
      |=> res_prio_r == $past(p.dflt))
      else $error("default priority not applied");
   acl_only_a: assert property (p.pkt_valid && p.src_en == 5'h01 &&
      p.src_valid[0] |=> res_prio_r == $past(p.src_prio[0]))
      else $error("rule priority not used");

endmodule

// ==== hw/pic_regs.sv ====
// Per-port ingress control registers behind an AXI4-Lite slave
// Operation
// - Write-done flag low while write pending
// - Read-done flag low while read pending
// - Byte-enable low write launches; enabled bytes move
// - Receive sniff marks received packets monitored
// - Transmit sniff marks transmitted packets monitored
// - Bit 1 makes port the sniffer port
// - Bit 7 picks highest available priority
// - Bit 6 ORs all available priorities
// - Bit 4 enables MAC lookup priority
// - Bit 3 enables VLAN entry priority
// - Bit 2 enables tag user priority
// - Bit 1 enables DSCP priority
// - Bit 0 enables rule-match priority
// - No result gives default port priority
module pic_regs
   import pic_pkg::*;
(
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rst_b,
   // AXI4-Lite write address and data
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [ADDR_W-1:0]  awaddr,
   input  wire logic               wvalid,
   output logic                    wready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   // AXI4-Lite write response
   output logic                    bvalid,
   input  wire logic               bready,
   output logic [1:0]              bresp,
   // AXI4-Lite read
   input  wire logic               arvalid,
   output logic                    arready,
   input  wire logic [ADDR_W-1:0]  araddr,
   output logic                    rvalid,
   input  wire logic               rready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   // Indirect rule entry engine
   output logic                    rule_req,
   output logic                    rule_dir,
   output logic [3:0]              rule_index,
   output logic [15:0]             rule_byte_en,
   input  wire logic               rule_done,
   // Mirroring
   input  wire logic               rx_pkt,
   input  wire logic               tx_pkt,
   output logic                    rx_monitored,
   output logic                    tx_monitored,
   output logic                    sniffer_port,
   // Ingress priority classification
   input  wire logic               cls_pkt_valid,
   input  wire logic [NSRC-1:0]    cls_src_valid,
   input  wire logic [3*NSRC-1:0]  cls_src_prio,
   output logic                    cls_prio_valid,
   output logic [2:0]              cls_prio
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   logic        awready_r, awready_nxt, wready_r;
   logic        bvalid_r, bvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt;
   logic        arready_r, arready_nxt;
   logic        rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0]  rresp_r, rresp_nxt;
   logic [7:0]  ctl_r, ctl_nxt;
   logic [7:0]  be_msb_r, be_msb_nxt;
   logic [7:0]  be_lsb_r, be_lsb_nxt;
   logic [7:0]  mirror_r, mirror_nxt;
   logic [7:0]  prio_r, prio_nxt;
   logic [2:0]  dflt_r, dflt_nxt;
   pic_eng_type eng_r, eng_nxt;
   logic        op_dir_r, op_dir_nxt;
   logic        req_r, req_nxt;
   logic [3:0]  idx_r, idx_nxt;
   logic [15:0] ben_r, ben_nxt;
   logic        rxm_r, rxm_nxt, txm_r, txm_nxt, snf_r, snf_nxt;
   logic        wr_fire, wr_ok, launch;
   logic [11:0] wr_idx, rd_idx;
   logic        wr_done_flag, rd_done_flag;

   pic_prio_if pif ();

   assign wr_fire      = awready_r && awvalid && wvalid;
   assign wr_idx       = awaddr[13:2];
   assign rd_idx       = araddr[13:2];
   assign wr_ok        = wr_fire && wstrb[0];
   assign launch       = wr_ok && wr_idx == IDX_BE_LSB
                         && awaddr[15:14] == 2'h0 && eng_r == ENG_IDLE;
   assign wr_done_flag = !(eng_r == ENG_BUSY && op_dir_r);
   assign rd_done_flag = !(eng_r == ENG_BUSY && !op_dir_r);

   // ***************************************************************
   // Bus handshakes: address and data are taken together
   // ***************************************************************
   always_comb
   begin
      awready_nxt = awvalid && wvalid && !awready_r && !bvalid_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      if (bvalid_r && bready)
         bvalid_nxt = 1'b0;
      if (wr_fire)
      begin
         bvalid_nxt = 1'b1;
         case (wr_idx)
            IDX_BE_MSB, IDX_BE_LSB, IDX_RULE_ACC,
            IDX_MIRROR, IDX_PRIO, IDX_DFLT:
               bresp_nxt = awaddr[15:14] == 2'h0 ? RESP_OKAY : RESP_SLVERR;
            default:
               bresp_nxt = RESP_SLVERR;
         endcase
      end
      arready_nxt = arvalid && !arready_r && !rvalid_r;
      rvalid_nxt  = rvalid_r && !rready;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (arready_r && arvalid)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = araddr[15:14] == 2'h0 ? RESP_OKAY : RESP_SLVERR;
         // Status bits show engine state, not stored values
         case (rd_idx)
            IDX_BE_MSB:   rdata_nxt = {24'h0, be_msb_r};
            IDX_BE_LSB:   rdata_nxt = {24'h0, be_lsb_r};
            IDX_RULE_ACC: rdata_nxt = {25'h0, wr_done_flag, rd_done_flag,
                                       ctl_r[4:0]};
            IDX_MIRROR:   rdata_nxt = {24'h0, mirror_r};
            IDX_PRIO:     rdata_nxt = {24'h0, prio_r};
            IDX_DFLT:     rdata_nxt = {29'h0, dflt_r};
            default:
            begin
               rdata_nxt = 32'h0;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
         if (araddr[15:14] != 2'h0)
            rdata_nxt = 32'h0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0;
         rresp_r   <= RESP_OKAY;
      end
      else
      begin
         awready_r <= awready_nxt;
         wready_r  <= awready_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   // ***************************************************************
   // Register file; only lane 0 carries data, reserved bits stay 0
   // ***************************************************************
   always_comb
   begin
      ctl_nxt    = ctl_r;
      be_msb_nxt = be_msb_r;
      be_lsb_nxt = be_lsb_r;
      mirror_nxt = mirror_r;
      prio_nxt   = prio_r;
      dflt_nxt   = dflt_r;
      if (wr_ok && awaddr[15:14] == 2'h0)
      begin
         case (wr_idx)
            IDX_RULE_ACC: ctl_nxt    = wdata[7:0] & MASK_RULE_ACC;
            IDX_BE_MSB:   be_msb_nxt = wdata[7:0];
            IDX_BE_LSB:   be_lsb_nxt = wdata[7:0];
            IDX_MIRROR:   mirror_nxt = wdata[7:0] & MASK_MIRROR;
            IDX_PRIO:     prio_nxt   = wdata[7:0] & MASK_PRIO;
            IDX_DFLT:     dflt_nxt   = wdata[2:0];
            default:      ctl_nxt    = ctl_r;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctl_r    <= RST_BYTE;
         be_msb_r <= RST_BYTE;
         be_lsb_r <= RST_BYTE;
         mirror_r <= RST_BYTE;
         prio_r   <= RST_BYTE;
         dflt_r   <= RST_DFLT;
      end
      else
      begin
         ctl_r    <= ctl_nxt;
         be_msb_r <= be_msb_nxt;
         be_lsb_r <= be_lsb_nxt;
         mirror_r <= mirror_nxt;
         prio_r   <= prio_nxt;
         dflt_r   <= dflt_nxt;
      end
   end

   // ***************************************************************
   // Indirect access engine; a launch while busy is dropped so that
   // the direction latched for the pending flags cannot change
   // ***************************************************************
   always_comb
   begin
      eng_nxt    = eng_r;
      op_dir_nxt = op_dir_r;
      req_nxt    = 1'b0;
      idx_nxt    = idx_r;
      ben_nxt    = ben_r;
      case (eng_r)
         ENG_IDLE:
            if (launch)
            begin
               eng_nxt    = ENG_BUSY;
               op_dir_nxt = ctl_r[RA_DIR];
               req_nxt    = 1'b1;
               idx_nxt    = ctl_r[3:0];
               ben_nxt    = {be_msb_r, wdata[7:0]};
            end
         ENG_BUSY:
            if (rule_done)
               eng_nxt = ENG_IDLE;
         default:
            eng_nxt = ENG_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         eng_r    <= ENG_IDLE;
         op_dir_r <= 1'b0;
         req_r    <= 1'b0;
         idx_r    <= 4'h0;
         ben_r    <= 16'h0;
      end
      else
      begin
         eng_r    <= eng_nxt;
         op_dir_r <= op_dir_nxt;
         req_r    <= req_nxt;
         idx_r    <= idx_nxt;
         ben_r    <= ben_nxt;
      end
   end

   // ***************************************************************
   // Mirroring marks, one cycle behind the packet strobe
   // ***************************************************************
   always_comb
   begin
      rxm_nxt = rx_pkt && mirror_r[MIR_RX];
      txm_nxt = tx_pkt && mirror_r[MIR_TX];
      snf_nxt = mirror_r[MIR_SNIFF];
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rxm_r <= 1'b0;
         txm_r <= 1'b0;
         snf_r <= 1'b0;
      end
      else
      begin
         rxm_r <= rxm_nxt;
         txm_r <= txm_nxt;
         snf_r <= snf_nxt;
      end
   end

   // ***************************************************************
   // Priority resolver
   // ***************************************************************
   assign pif.pkt_valid = cls_pkt_valid;
   assign pif.src_en    = prio_r[NSRC-1:0];
   assign pif.src_valid = cls_src_valid;
   assign pif.src_prio  = cls_src_prio;
   assign pif.highest   = prio_r[PR_HIGHEST];
   assign pif.or_mode   = prio_r[PR_OR];
   assign pif.dflt      = dflt_r;

   pic_prio_resolve u_resolve
   (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .p       (pif.comb)
   );

   // Outputs
   assign awready        = awready_r;
   assign wready         = wready_r;
   assign bvalid         = bvalid_r;
   assign bresp          = bresp_r;
   assign arready        = arready_r;
   assign rvalid         = rvalid_r;
   assign rdata          = rdata_r;
   assign rresp          = rresp_r;
   assign rule_req       = req_r;
   assign rule_dir       = op_dir_r;
   assign rule_index     = idx_r;
   assign rule_byte_en   = ben_r;
   assign rx_monitored   = rxm_r;
   assign tx_monitored   = txm_r;
   assign sniffer_port   = snf_r;
   assign cls_prio_valid = pif.res_valid;
   assign cls_prio       = pif.res_prio;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_launch_wr;
      launch && ctl_r[RA_DIR];
   endsequence
   sequence s_launch_rd;
      launch && !ctl_r[RA_DIR];
   endsequence

   write_pending_a: assert property (s_launch_wr |=>
      !wr_done_flag && rd_done_flag && rule_req && rule_dir)
      else $error("write launch did not clear write flag");
   read_pending_a: assert property (s_launch_rd |=>
      !rd_done_flag && wr_done_flag && rule_req && !rule_dir)
      else $error("read launch did not clear read flag");
   done_flags_a: assert property (eng_r == ENG_BUSY && rule_done
      |=> wr_done_flag && rd_done_flag && !rule_req)
      else $error("flags not restored on completion");
   entry_select_a: assert property (launch
      |=> rule_index == $past(ctl_r[3:0]) && rule_dir == $past(ctl_r[4]))
      else $error("entry index or direction not carried");
   byte_enable_a: assert property (launch
      |=> rule_byte_en == {$past(be_msb_r), $past(wdata[7:0])} ##1 !rule_req)
      else $error("byte enables wrong or request too long");
   rx_sniff_a: assert property (rx_pkt
      |=> rx_monitored == $past(mirror_r[MIR_RX]))
      else $error("receive monitoring mark wrong");
   tx_sniff_a: assert property (tx_pkt
      |=> tx_monitored == $past(mirror_r[MIR_TX]))
      else $error("transmit monitoring mark wrong");
   sniffer_set_a: assert property (wr_ok && wr_idx == IDX_MIRROR
      && awaddr[15:14] == 2'h0 |=> ##1 sniffer_port == $past(wdata[1], 2))
      else $error("sniffer port bit not applied");

endmodule

// ==== testbench/port_ingress_ctrl_regs_bench.sv ====
// Self-checking bench for the per-port ingress control register block
module port_ingress_ctrl_regs_bench
   import pic_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic               ref_clk = 1'b0;
   logic               rst_b = 1'b0;
   logic               awvalid = 1'b0, awready, wvalid = 1'b0, wready;
   logic [ADDR_W-1:0]  awaddr = '0, araddr = '0;
   logic [31:0]        wdata = '0, rdata;
   logic [3:0]         wstrb = '0;
   logic               bvalid, bready = 1'b0, arvalid = 1'b0, arready;
   logic               rvalid, rready = 1'b0;
   logic [1:0]         bresp, rresp;
   logic               rule_req, rule_dir, rule_done = 1'b0;
   logic [3:0]         rule_index;
   logic [15:0]        rule_byte_en;
   logic               rx_pkt = 1'b0, tx_pkt = 1'b0;
   logic               rx_monitored, tx_monitored, sniffer_port;
   logic               cls_pkt_valid = 1'b0, cls_prio_valid;
   logic [NSRC-1:0]    cls_src_valid = '0;
   logic [3*NSRC-1:0]  cls_src_prio = '0;
   logic [2:0]         cls_prio;
   logic [20:0]        launches[$];
   int                 fail_count = 0, n_compared = 0, cycles = 0;

   // 250 MHz core clock
   always #2 ref_clk = ~ref_clk;

   pic_regs u_pic_regs (
      .ref_clk(ref_clk), .rst_b(rst_b), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp),
      .rule_req(rule_req), .rule_dir(rule_dir), .rule_index(rule_index),
      .rule_byte_en(rule_byte_en), .rule_done(rule_done),
      .rx_pkt(rx_pkt), .tx_pkt(tx_pkt), .rx_monitored(rx_monitored),
      .tx_monitored(tx_monitored), .sniffer_port(sniffer_port),
      .cls_pkt_valid(cls_pkt_valid), .cls_src_valid(cls_src_valid),
      .cls_src_prio(cls_src_prio), .cls_prio_valid(cls_prio_valid),
      .cls_prio(cls_prio)
   );

   // ***************************************************************
   // Checking and bus tasks
   // ***************************************************************
   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Address and data offered together, both held until taken
   task automatic axi_wr(input logic [11:0] idx, input logic [7:0] d,
                         input logic [3:0] s, input logic [1:0] er);
      @(posedge ref_clk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'($urandom), d};
      wstrb <= s;
      bready <= 1'b1;
      do @(posedge ref_clk); while (awready !== 1'b1 || wready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge ref_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk_resp(bresp, er);
   endtask

   task automatic axi_rd(input logic [11:0] idx, input logic [7:0] ed,
                         input logic [1:0] er);
      @(posedge ref_clk);
      arvalid <= 1'b1;
      araddr <= {2'h0, idx, 2'h0};
      rready <= 1'b1;
      do @(posedge ref_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk_resp(rresp, er);
      chk_data(rdata, {24'h0, ed});
   endtask

   // Reference priority merge; assumes nothing about the resolver
   function automatic logic [2:0] model_prio(input logic [7:0] p,
      input logic [2:0] d, input logic [4:0] v, input logic [14:0] pr);
      int         best;
      int         first;
      logic [2:0] orv;
      logic [4:0] en;
      en = p[4:0] & v;
      best = 0;
      first = 0;
      orv = 3'h0;
      for (int i = 4; i >= 0; i--)
         if (en[i])
         begin
            first = i;
            orv = orv | pr[3*i +: 3];
            if (int'(pr[3*i +: 3]) > best)
               best = int'(pr[3*i +: 3]);
         end
      if (en == 5'h0)
         return d;
      if (p[7])
         return 3'(best);
      if (p[6])
         return orv;
      return pr[3*first +: 3];
   endfunction

   task automatic report_and_stop;
      if (fail_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Launch capture and hang guard; ceiling is well above the run length
   always @(posedge ref_clk)
   begin
      cycles++;
      if (rule_req === 1'b1)
         launches.push_back({rule_dir, rule_index, rule_byte_en});
      if (cycles == 20000)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      logic [11:0] tidx[4];
      logic [7:0]  tmsk[4];
      logic [7:0]  m, p, bh, bl;
      logic [3:0]  ix;
      logic [4:0]  v;
      logic [14:0] pr;
      logic [2:0]  d;
      logic        dir;
      tidx = '{IDX_RULE_ACC, IDX_MIRROR, IDX_PRIO, IDX_DFLT};
      tmsk = '{8'h7f, MASK_MIRROR, MASK_PRIO, 8'h07};
      void'($urandom(32'h7fa50a17));
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      axi_rd(IDX_RULE_ACC, 8'h60, RESP_OKAY);
      axi_rd(12'h700, 8'h00, RESP_SLVERR);
      axi_wr(12'h700, 8'hff, 4'hf, RESP_SLVERR);
      // Reset values, writable bits, and byte strobe refusal
      for (int i = 0; i < 4; i++)
      begin
         axi_rd(tidx[i], (i == 0) ? 8'h60 : 8'h00, RESP_OKAY);
         axi_wr(tidx[i], 8'hff, 4'hf, RESP_OKAY);
         axi_rd(tidx[i], tmsk[i], RESP_OKAY);
         axi_wr(tidx[i], 8'h00, 4'he, RESP_OKAY);
         axi_rd(tidx[i], tmsk[i], RESP_OKAY);
         axi_wr(tidx[i], 8'h00, 4'hf, RESP_OKAY);
      end
      // Indirect rule access in both directions, busy launch dropped
      for (int k = 0; k < 6; k++)
      begin
         dir = k[0];
         ix = 4'($urandom);
         bh = 8'($urandom);
         bl = 8'($urandom);
         axi_wr(IDX_RULE_ACC, {3'h0, dir, ix}, 4'hf, RESP_OKAY);
         axi_wr(IDX_BE_MSB, bh, 4'hf, RESP_OKAY);
         axi_wr(IDX_BE_LSB, bl, 4'hf, RESP_OKAY);
         // One edge more so the capture process has seen the pulse
         @(posedge ref_clk);
         chk_data(32'(launches.size()), 32'h1);
         chk_data({11'h0, launches.pop_front()}, {11'h0, dir, ix, bh, bl});
         axi_rd(IDX_RULE_ACC, {1'b0, ~dir, dir, dir, ix}, RESP_OKAY);
         axi_wr(IDX_BE_LSB, bl, 4'hf, RESP_OKAY);
         axi_rd(IDX_BE_MSB, bh, RESP_OKAY);
         axi_rd(IDX_BE_LSB, bl, RESP_OKAY);
         chk_data(32'(launches.size()), 32'h0);
         @(posedge ref_clk);
         rule_done <= 1'b1;
         @(posedge ref_clk);
         rule_done <= 1'b0;
         axi_rd(IDX_RULE_ACC, {3'h3, dir, ix}, RESP_OKAY);
      end
      // Mirroring controls; the global enable lives outside this block
      for (int k = 0; k < 8; k++)
      begin
         m = 8'($urandom);
         axi_wr(IDX_MIRROR, m, 4'hf, RESP_OKAY);
         repeat (2) @(posedge ref_clk);
         chk_data({31'h0, sniffer_port}, {31'h0, m[MIR_SNIFF]});
         rx_pkt <= 1'b1;
         tx_pkt <= 1'b1;
         @(posedge ref_clk);
         rx_pkt <= 1'b0;
         tx_pkt <= 1'b0;
         @(posedge ref_clk);
         chk_data({31'h0, rx_monitored}, {31'h0, m[MIR_RX]});
         chk_data({31'h0, tx_monitored}, {31'h0, m[MIR_TX]});
      end
      // Priority classification against the reference merge
      for (int k = 0; k < 40; k++)
      begin
         // Odd passes keep to one priority bit, even passes mix modes
         p = k[0] ? 8'h01 << ((k / 2) % 8) : 8'($urandom);
         p = p & MASK_PRIO;
         d = 3'($urandom);
         v = (k % 8 == 0) ? 5'h0 : 5'($urandom);
         pr = 15'($urandom);
         axi_wr(IDX_PRIO, p, 4'hf, RESP_OKAY);
         axi_wr(IDX_DFLT, {5'h0, d}, 4'hf, RESP_OKAY);
         @(posedge ref_clk);
         cls_pkt_valid <= 1'b1;
         cls_src_valid <= v;
         cls_src_prio <= pr;
         @(posedge ref_clk);
         cls_pkt_valid <= 1'b0;
         @(posedge ref_clk);
         chk_data({28'h0, cls_prio_valid, cls_prio},
                  {28'h0, 1'b1, model_prio(p, d, v, pr)});
      end
      report_and_stop();
   end

endmodule
